// file: rtl/mlic_ctrl.sv
// mlic_ctrl: multilevel interrupt controller, arbitration and nesting
// assumes core signals are synchronous; core pulses instr_done_i, interrupt_return_instr_i,
// prot_unlock_i and wake_i for one cycle, and raises locked_exec_i level
// Behaviour
// R1 - maskable acknowledge needs global enable unchanged
// R2 - level enable gates each level
// R3 - acknowledge or pend; load vector address
// R4 - one instruction before serving pending
// R5 - return restores previous level state
// R6 - software saves status, ends with return
// R7 - each source own vector; reset lowest
// R8 - flags set even when disabled
// R9 - flags auto clear on vector, write-one clear
// R10 - blocked requests stay pending, priority order
// R11 - locked section execution blocks acknowledge
// R12 - unlock signature blocks servicing four cycles
// R13 - non-maskable ignores global enable, unpreemptable
// R14 - lowest vector non-maskable served first
// R15 - three cycle response, three cycle jump
// R16 - wake adds five cycles plus startup
// R17 - return takes four or five cycles
// R18 - level code decode 00 off..11 high
// R19 - higher level preempts, lower resumes
// R20 - static priority except low round-robin
// R21 - last low vector lowest next
// R22 - boot select and vector section placement
// R23 - level disable effective one cycle later
// R24 - round-robin enable selects ordering
// R25 - last low vector register kept
// R26 - running flags set/cleared per level
// R27 - acknowledged index signalled same cycle
`timescale 1ns/1ps
module mlic_ctrl (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic [15:0]               cond_i,
  input  wire logic [15:0]               clr_flag_i,
  input  wire logic [15:0]               autoclr_i,
  input  wire logic [31:0]               level_i,
  input  wire logic [15:0]               nmi_src_i,
  input  wire logic                      global_en_i,
  input  wire logic                      low_level_enable_i,
  input  wire logic                      mid_level_enable_i,
  input  wire logic                      high_level_enable_i,
  input  wire logic                      round_robin_enable_i,
  input  wire logic                      vector_section_select_i,
  input  wire logic                      boot_reset_select_i,
  input  wire logic [15:0]               boot_reset_addr_i,
  input  wire logic                      pri_wr_i,
  input  wire logic [7:0]                pri_wdata_i,
  input  wire logic                      instr_done_i,
  input  wire logic                      interrupt_return_instr_i,
  input  wire logic                      pc_wide_i,
  input  wire logic                      prot_unlock_i,
  input  wire logic                      locked_exec_i,
  input  wire logic                      asleep_i,
  input  wire logic                      wake_i,
  input  wire logic [7:0]                startup_cyc_i,
  output logic [15:0]                    flag_o,
  output logic                           ack_o,
  output logic [3:0]                     ack_idx_o,
  output logic [15:0]                    vector_address_o,
  output logic [15:0]                    reset_addr_o,
  output logic                           pc_load_o,
  output logic                           cpu_stall_o,
  output logic                           low_level_running_o,
  output logic                           mid_level_running_o,
  output logic                           high_level_running_o,
  output logic                           non_maskable_running_o,
  output logic [7:0]                     last_low_vector_reg_o
);
  typedef enum logic [2:0] {ST_RUN, ST_WAKE, ST_PUSH, ST_JUMP, ST_RET} mlic_state_t;
  mlic_state_t state_q, state_d;
  logic [15:0] flag_q, flag_d;
  logic [3:0]  run_q, run_d;
  logic [7:0]  pri_q, pri_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [2:0]  prot_q, prot_d;
  logic        gap_q, gap_d;
  logic        ie_gap_q, ie_gap_d;
  logic [3:0]  idx_q, idx_d;
  logic        isnmi_q, isnmi_d;
  logic [1:0]  lvl_q, lvl_d;
  logic [15:0] vec_q, vec_d;
  logic [2:0]  en_q;

  // per-level request masks
  logic [15:0] req_nmi, req_hi, req_mid, req_lo;
  always_comb begin
    for (int s = 0; s < mlic_pkg::NUM_SRC; s++) begin
      logic [1:0] l;
      l = level_i[2*s +: 2];
      req_nmi[s] = flag_q[s] & nmi_src_i[s];
      req_hi[s]  = flag_q[s] & ~nmi_src_i[s] & (l == mlic_pkg::LVL_HIGH) & en_q[2]; // R18 R2
      req_mid[s] = flag_q[s] & ~nmi_src_i[s] & (l == mlic_pkg::LVL_MID)  & en_q[1]; // R18 R2
      req_lo[s]  = flag_q[s] & ~nmi_src_i[s] & (l == mlic_pkg::LVL_LOW)  & en_q[0]; // R18 R2
    end
  end

  logic nmi_hit, hi_hit, mid_hit, lo_hit;
  logic [3:0] nmi_idx, hi_idx, mid_idx, lo_idx;
  mlic_prio_pick #(.N(16), .W(4)) u_nmi (.req_i(req_nmi), .rotate_i(1'b0), // R14 R20
    .last_i(4'h0), .hit_o(nmi_hit), .idx_o(nmi_idx));
  mlic_prio_pick #(.N(16), .W(4)) u_hi (.req_i(req_hi), .rotate_i(1'b0), // R20
    .last_i(4'h0), .hit_o(hi_hit), .idx_o(hi_idx));
  mlic_prio_pick #(.N(16), .W(4)) u_mid (.req_i(req_mid), .rotate_i(1'b0), // R20
    .last_i(4'h0), .hit_o(mid_hit), .idx_o(mid_idx));
  mlic_prio_pick #(.N(16), .W(4)) u_lo (.req_i(req_lo), .rotate_i(round_robin_enable_i), // R21 R24
    .last_i(pri_q[3:0]), .hit_o(lo_hit), .idx_o(lo_idx));

  // winner selection against running levels
  logic       win;
  logic       win_nmi;
  logic [1:0] win_lvl;
  logic [3:0] win_idx;
  logic       allowed;
  always_comb begin
    win = 1'b0;
    win_nmi = 1'b0;
    win_lvl = mlic_pkg::LVL_OFF;
    win_idx = 4'h0;
    allowed = instr_done_i & gap_q & (prot_q == 3'h0) & ~locked_exec_i // R4 R11 R12 R15
              & ~run_q[mlic_pkg::RUN_NMI];                              // R13
    if (nmi_hit) begin
      win = 1'b1; win_nmi = 1'b1; win_idx = nmi_idx;                    // R13
    end else if (global_en_i && ie_gap_q) begin                         // R1 R4
      if (hi_hit && !run_q[mlic_pkg::RUN_HIGH]) begin                   // R19
        win = 1'b1; win_lvl = mlic_pkg::LVL_HIGH; win_idx = hi_idx;
      end else if (mid_hit && run_q[2:1] == 2'h0) begin
        win = 1'b1; win_lvl = mlic_pkg::LVL_MID; win_idx = mid_idx;
      end else if (lo_hit && run_q[2:0] == 3'h0) begin                  // R10
        win = 1'b1; win_lvl = mlic_pkg::LVL_LOW; win_idx = lo_idx;
      end
    end
  end
  logic take;
  assign take = allowed & win & (state_q == ST_RUN);

  logic [15:0] vbase;
  assign vbase = vector_section_select_i ? (boot_reset_addr_i + mlic_pkg::VEC_BASE_OFFSET)
                                         : mlic_pkg::VEC_BASE_OFFSET;       // R22
  assign reset_addr_o = boot_reset_select_i ? mlic_pkg::RESET_ADDR_APP
                                            : boot_reset_addr_i;            // R7 R22

  always_comb begin
    state_d = state_q;
    flag_d  = flag_q;
    run_d   = run_q;
    pri_d   = pri_q;
    cnt_d   = cnt_q;
    gap_d   = gap_q;
    ie_gap_d = ie_gap_q;
    idx_d   = idx_q;
    isnmi_d = isnmi_q;
    lvl_d   = lvl_q;
    vec_d   = vec_q;
    prot_d  = prot_unlock_i ? 3'(mlic_pkg::PROT_BLOCK_CYC) :
              (prot_q != 3'h0 ? prot_q - 3'h1 : 3'h0);                       // R12
    if (pri_wr_i) pri_d = pri_wdata_i;                                       // R25
    if (instr_done_i) gap_d = 1'b1;                                          // R4
    // only maskable requests wait for an instruction after enabling
    ie_gap_d = global_en_i & (ie_gap_q | instr_done_i);                      // R4
    case (state_q)
      ST_RUN: begin
        if (take) begin
          idx_d   = win_idx;
          isnmi_d = win_nmi;
          lvl_d   = win_lvl;
          vec_d   = vbase + 16'({12'h000, win_idx} * mlic_pkg::VEC_STRIDE); // R3 R7
          if (!win_nmi && win_lvl == mlic_pkg::LVL_LOW && round_robin_enable_i)
            pri_d = {4'h0, win_idx};                                         // R21 R25
          if (asleep_i) begin
            state_d = ST_WAKE;                                               // R16
            cnt_d   = 8'(mlic_pkg::WAKE_EXTRA_CYC) + startup_cyc_i;
          end else begin
            state_d = ST_PUSH;                                               // R15
            cnt_d   = 8'(mlic_pkg::PUSH_CYC);
          end
          if (win_nmi) run_d[mlic_pkg::RUN_NMI] = 1'b1;                      // R26
          else run_d[win_lvl - 2'h1] = 1'b1;                                 // R26
        end else if (interrupt_return_instr_i) begin
          // clear the innermost running level only
          if (run_q[mlic_pkg::RUN_NMI]) run_d[mlic_pkg::RUN_NMI] = 1'b0;     // R5 R26
          else if (run_q[2]) run_d[2] = 1'b0;
          else if (run_q[1]) run_d[1] = 1'b0;
          else run_d[0] = 1'b0;
          state_d = ST_RET;                                                  // R17
          cnt_d   = pc_wide_i ? 8'(mlic_pkg::RET_LONG_CYC) : 8'(mlic_pkg::RET_SHORT_CYC);
          gap_d   = 1'b0;                                                    // R4
        end
      end
      ST_WAKE: begin
        if (wake_i || cnt_q <= 8'h1) begin
          state_d = ST_PUSH;
          cnt_d   = 8'(mlic_pkg::PUSH_CYC);
        end else cnt_d = cnt_q - 8'h1;
      end
      ST_PUSH: begin
        if (cnt_q == 8'h1) begin
          state_d = ST_JUMP;                                                 // R15
          cnt_d   = 8'(mlic_pkg::JUMP_CYC);
        end else cnt_d = cnt_q - 8'h1;
      end
      ST_JUMP, ST_RET: begin
        if (cnt_q == 8'h1) begin
          state_d = ST_RUN;
          gap_d   = 1'b0;                                                    // R4
        end else cnt_d = cnt_q - 8'h1;
      end
      default: state_d = ST_RUN;
    endcase
    // flags: set wins over any clear
    for (int s = 0; s < mlic_pkg::NUM_SRC; s++) begin
      if (clr_flag_i[s]) flag_d[s] = 1'b0;                                   // R9
      if (take && win_idx == 4'(s) && autoclr_i[s]) flag_d[s] = 1'b0;        // R9 R27
      if (cond_i[s]) flag_d[s] = 1'b1;                                       // R8
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_RUN;
      flag_q  <= 16'h0000;
      run_q   <= mlic_pkg::RUN_RESET;
      pri_q   <= mlic_pkg::PRI_RESET;
      cnt_q   <= 8'h00;
      prot_q  <= 3'h0;
      gap_q   <= 1'b0;
      ie_gap_q <= 1'b0;
      idx_q   <= 4'h0;
      isnmi_q <= 1'b0;
      lvl_q   <= 2'h0;
      vec_q   <= 16'h0000;
      en_q    <= 3'h0;
    end else begin
      state_q <= state_d;
      flag_q  <= flag_d;
      run_q   <= run_d;
      pri_q   <= pri_d;
      cnt_q   <= cnt_d;
      prot_q  <= prot_d;
      gap_q   <= gap_d;
      ie_gap_q <= ie_gap_d;
      idx_q   <= idx_d;
      isnmi_q <= isnmi_d;
      lvl_q   <= lvl_d;
      vec_q   <= vec_d;
      en_q    <= {high_level_enable_i, mid_level_enable_i, low_level_enable_i}; // R23
    end
  end

  assign flag_o                 = flag_q;
  assign ack_o                  = take;                                      // R27
  assign ack_idx_o              = win_idx;                                   // R27
  assign vector_address_o       = vec_q;
  assign pc_load_o              = (state_q == ST_JUMP) && (cnt_q == 8'(mlic_pkg::JUMP_CYC)); // R3
  assign cpu_stall_o            = (state_q != ST_RUN);
  assign low_level_running_o    = run_q[mlic_pkg::RUN_LOW];
  assign mid_level_running_o    = run_q[mlic_pkg::RUN_MID];
  assign high_level_running_o   = run_q[mlic_pkg::RUN_HIGH];
  assign non_maskable_running_o = run_q[mlic_pkg::RUN_NMI];
  assign last_low_vector_reg_o  = pri_q;

  a_ack_needs_gie: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ack_o && !non_maskable_running_o |-> global_en_i || nmi_src_i[ack_idx_o]) // R1
    else $error("maskable ack without global enable");
  a_no_ack_in_nmi: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    non_maskable_running_o |-> !ack_o)                                        // R13
    else $error("ack during non-maskable handler");
  a_prot_block: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    prot_unlock_i |=> !ack_o [*4])                                            // R12
    else $error("ack inside protection window");
  a_lock_block: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    locked_exec_i |-> !ack_o)                                                 // R11
    else $error("ack in locked section");
  a_ack_pc_load: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ack_o && !asleep_i |-> ##3 pc_load_o)                                     // R15
    else $error("vector load not at third cycle");
  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cond_i[0] |=> flag_o[0])                                                  // R8
    else $error("flag not set by condition");
  a_run_set: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ack_o && nmi_src_i[ack_idx_o] |=> non_maskable_running_o)                 // R26
    else $error("running flag not set");

  sequence s_ret_short;
    cpu_stall_o [*4] ##1 !cpu_stall_o;
  endsequence
  sequence s_ret_long;
    cpu_stall_o [*5] ##1 !cpu_stall_o;
  endsequence
  a_interrupt_return_instr_len: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    interrupt_return_instr_i && !ack_o && !cpu_stall_o && !pc_wide_i |=> s_ret_short)         // R17
    else $error("return length wrong");
  a_interrupt_return_instr_long: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    interrupt_return_instr_i && !ack_o && !cpu_stall_o && pc_wide_i |=> s_ret_long)           // R17
    else $error("long return length wrong");
  a_level_off: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !$past(low_level_enable_i) && ack_o && !nmi_src_i[ack_idx_o]
      |-> level_i[2*ack_idx_o +: 2] != mlic_pkg::LVL_LOW)                     // R23
    else $error("disabled low level acknowledged");
  a_run_level: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ack_o |=> (isnmi_q ? non_maskable_running_o : run_q[lvl_q - 2'h1]))      // R26
    else $error("running flag of taken level not set");
  a_flag_autoclr: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ack_o && autoclr_i[ack_idx_o] && !cond_i[ack_idx_o] |=> !flag_o[idx_q])  // R9
    else $error("taken flag not auto cleared");
endmodule // mlic_ctrl

// file: rtl/mlic_pkg.sv
// mlic_pkg: constants shared by the multilevel interrupt controller
// assumes the core and peripherals share one clock with the controller
package mlic_pkg;
  localparam int NUM_SRC    = 16;
  localparam int SRC_W      = 4;
  localparam int PC_W       = 16;
  localparam int LVL_W      = 2;
  localparam int PRI_W      = 8;
  // level codes
  localparam logic [1:0] LVL_OFF  = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_MID  = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;
  // vector placement
  localparam logic [15:0] RESET_ADDR_APP  = 16'h0000;
  localparam logic [15:0] VEC_BASE_OFFSET = 16'h0002;
  localparam logic [15:0] VEC_STRIDE      = 16'h0002;
  // timing, in cpu cycles, and reset values
  localparam int PROT_BLOCK_CYC  = 4;
  localparam int RESP_MIN_CYC    = 3;
  localparam int PUSH_CYC        = 2;
  localparam int JUMP_CYC        = 3;
  localparam int WAKE_EXTRA_CYC  = 5;
  localparam int RET_SHORT_CYC   = 4;
  localparam int RET_LONG_CYC    = 5;
  localparam logic [7:0] PRI_RESET = 8'h00;
  localparam logic [3:0] RUN_RESET = 4'h0;
  // running flag positions
  localparam int RUN_LOW  = 0;
  localparam int RUN_MID  = 1;
  localparam int RUN_HIGH = 2;
  localparam int RUN_NMI  = 3;
endpackage

// file: rtl/mlic_prio_pick.sv
// mlic_prio_pick: lowest-index pick among requests, with optional rotation
// assumes a purely combinational use inside one clock domain
`timescale 1ns/1ps
module mlic_prio_pick #(
  parameter int N = 16,
  parameter int W = 4
) (
  input  wire logic [N-1:0] req_i,
  input  wire logic         rotate_i,
  input  wire logic [W-1:0] last_i,
  output logic              hit_o,
  output logic [W-1:0]      idx_o
);
  logic [2*N-1:0] dbl;
  logic [W:0]     start;
  logic [W:0]     pos;
  always_comb begin
    dbl   = {req_i, req_i};
    start = rotate_i ? ({1'b0, last_i} + (W+1)'(1)) : '0;
    hit_o = 1'b0;
    idx_o = '0;
    // search from start, first hit wins: static when start is zero
    for (int i = 2*N-1; i >= 0; i--) begin
      pos = start + (W+1)'(i);
      if (i < N && dbl[pos]) begin
        hit_o = 1'b1;
        idx_o = W'(pos);
      end
    end
  end
endmodule // mlic_prio_pick

// file: tb/mlic_core_model.sv
// mlic_core_model: behavioural processor core beside the interrupt controller
// assumes one shared clock; the bench requests interrupt returns through ret_req_i
`timescale 1ns/1ps
module mlic_core_model (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic stall_i,
  input  wire logic run_i,
  input  wire logic ret_req_i,
  output logic      instr_done_o,
  output logic      interrupt_return_instr_o
);
  // handlers always end with the interrupt return, never while stalled
  initial begin
    instr_done_o = 1'b0;
    interrupt_return_instr_o       = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      #2;
      interrupt_return_instr_o = ret_req_i && !stall_i && reset_n_i;
      instr_done_o = run_i && reset_n_i && !stall_i && !instr_done_o && !interrupt_return_instr_o;
    end
  end
endmodule // mlic_core_model

// file: tb/multilevel_interrupt_controller_tb_top.sv
// multilevel_interrupt_controller_tb_top: self-checking bench for mlic_ctrl
// assumes mlic_core_model supplies instruction completions and returns
`timescale 1ns/1ps
module multilevel_interrupt_controller_tb_top;
  logic ref_clk_i, reset_n_i, global_en_i, low_level_enable_i, mid_level_enable_i;
  logic high_level_enable_i, round_robin_enable_i, vector_section_select_i;
  logic boot_reset_select_i, pri_wr_i, instr_done_i, interrupt_return_instr_i, pc_wide_i, prot_unlock_i;
  logic locked_exec_i, asleep_i, wake_i, ack_o, pc_load_o, cpu_stall_o, ret_req, run;
  logic low_level_running_o, mid_level_running_o, high_level_running_o;
  logic non_maskable_running_o;
  logic [15:0] cond_i, clr_flag_i, autoclr_i, nmi_src_i, boot_reset_addr_i;
  logic [15:0] flag_o, vector_address_o, reset_addr_o, acks;
  logic [31:0] level_i;
  logic [7:0]  pri_wdata_i, startup_cyc_i, last_low_vector_reg_o;
  logic [3:0]  ack_idx_o;
  int          num_errors, check_count, cycles;

  mlic_ctrl i_dut (.ref_clk_i, .reset_n_i, .cond_i, .clr_flag_i, .autoclr_i, .level_i,
    .nmi_src_i, .global_en_i, .low_level_enable_i, .mid_level_enable_i,
    .high_level_enable_i, .round_robin_enable_i, .vector_section_select_i,
    .boot_reset_select_i, .boot_reset_addr_i, .pri_wr_i, .pri_wdata_i, .instr_done_i,
    .interrupt_return_instr_i, .pc_wide_i, .prot_unlock_i, .locked_exec_i, .asleep_i, .wake_i,
    .startup_cyc_i, .flag_o, .ack_o, .ack_idx_o, .vector_address_o, .reset_addr_o,
    .pc_load_o, .cpu_stall_o, .low_level_running_o, .mid_level_running_o,
    .high_level_running_o, .non_maskable_running_o, .last_low_vector_reg_o);

  mlic_core_model i_core (.ref_clk_i, .reset_n_i, .stall_i(cpu_stall_o), .run_i(run),
    .ret_req_i(ret_req), .instr_done_o(instr_done_i), .interrupt_return_instr_o(interrupt_return_instr_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(negedge ref_clk_i) if (ack_o === 1'b1) acks++;

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic raise(input logic [15:0] m);
    tick();
    cond_i = m;
    tick();
    cond_i = 16'h0000;
  endtask

  task automatic serve(input logic [3:0] e);
    logic [15:0] base;
    int          n;
    base = vector_section_select_i ? boot_reset_addr_i + mlic_pkg::VEC_BASE_OFFSET
                                   : mlic_pkg::VEC_BASE_OFFSET;
    n = 0;
    @(negedge ref_clk_i);
    while (ack_o !== 1'b1 && n < 60) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("ack", 16'h0001, {15'h0, ack_o});
    chk("ack_idx", {12'h0, e}, {12'h0, ack_idx_o});
    @(negedge ref_clk_i);
    chk("vector", base + mlic_pkg::VEC_STRIDE * {12'h0, e}, vector_address_o);
    chk("stall", 16'h0001, {15'h0, cpu_stall_o});
    repeat (2) @(negedge ref_clk_i);
    chk("pc_load", 16'h0001, {15'h0, pc_load_o});
    chk("flag_auto", 16'h0, {15'h0, flag_o[e]});
    tick();
  endtask

  task automatic do_ret();
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (cpu_stall_o !== 1'b0 && n < 30);
    // core idles while the return drains so a pending ack is not missed
    run = 1'b0;
    ret_req = 1'b1;
    tick();
    ret_req = 1'b0;
    tick(8);
    run = 1'b1;
  endtask

  task automatic quiet(input int n);
    logic [15:0] a;
    a = acks;
    tick(n);
    chk("no_ack", a, acks);
  endtask

  task automatic test_gating();
    level_i[11:10] = mlic_pkg::LVL_LOW;
    raise(16'h00A0);
    quiet(12);
    chk("flag_held", 16'h00A0, flag_o);
    clr_flag_i = 16'h0080;
    tick();
    clr_flag_i = 16'h0000;
    tick();
    chk("flag_w1c", 16'h0020, flag_o);
    global_en_i = 1'b1;
    serve(4'h5);
    chk("low_run", 16'h1, {15'h0, low_level_running_o});
    do_ret();
    chk("low_done", 16'h0, {15'h0, low_level_running_o});
  endtask

  task automatic test_nesting();
    level_i[7:6] = mlic_pkg::LVL_MID;
    level_i[19:18] = mlic_pkg::LVL_MID;
    level_i[25:24] = mlic_pkg::LVL_HIGH;
    pc_wide_i = 1'b1;
    raise(16'h0208);
    serve(4'h3);
    raise(16'h1000);
    serve(4'hC);
    chk("mid_kept", 16'h1, {15'h0, mid_level_running_o});
    do_ret();
    chk("hi_done", 16'h0, {15'h0, high_level_running_o});
    chk("mid_back", 16'h1, {15'h0, mid_level_running_o});
    do_ret();
    serve(4'h9);
    do_ret();
  endtask

  task automatic test_nmi();
    global_en_i = 1'b0;
    nmi_src_i = 16'h0044;
    level_i[5:4] = mlic_pkg::LVL_HIGH;
    level_i[13:12] = mlic_pkg::LVL_HIGH;
    level_i[1:0] = mlic_pkg::LVL_HIGH;
    raise(16'h0044);
    serve(4'h2);
    chk("nmi_run", 16'h1, {15'h0, non_maskable_running_o});
    global_en_i = 1'b1;
    raise(16'h0001);
    quiet(15);
    do_ret();
    serve(4'h6);
    do_ret();
    serve(4'h0);
    do_ret();
  endtask

  task automatic test_round_robin();
    round_robin_enable_i = 1'b1;
    vector_section_select_i = 1'b1;
    level_i[3:2] = mlic_pkg::LVL_LOW;
    level_i[9:8] = mlic_pkg::LVL_LOW;
    raise(16'h0002);
    serve(4'h1);
    chk("last_low", 16'h0001, {8'h0, last_low_vector_reg_o});
    do_ret();
    raise(16'h0012);
    serve(4'h4);
    do_ret();
    serve(4'h1);
    do_ret();
    boot_reset_select_i = 1'b1;
    tick();
    chk("reset_app", mlic_pkg::RESET_ADDR_APP, reset_addr_o);
    boot_reset_select_i = 1'b0;
    tick();
    chk("reset_boot", boot_reset_addr_i, reset_addr_o);
  endtask

  task automatic test_misc();
    int n;
    pri_wr_i = 1'b1;
    pri_wdata_i = 8'h03;
    tick();
    pri_wr_i = 1'b0;
    round_robin_enable_i = 1'b0;
    tick();
    chk("pri_write", 16'h0003, {8'h0, last_low_vector_reg_o});
    raise(16'h0012);
    serve(4'h1);
    chk("pri_kept", 16'h0003, {8'h0, last_low_vector_reg_o});
    do_ret();
    serve(4'h4);
    do_ret();
    low_level_enable_i = 1'b0;
    raise(16'h0020);
    quiet(12);
    chk("flag_pend", 16'h0020, flag_o);
    low_level_enable_i = 1'b1;
    serve(4'h5);
    do_ret();
    locked_exec_i = 1'b1;
    raise(16'h0008);
    quiet(12);
    locked_exec_i = 1'b0;
    serve(4'h3);
    do_ret();
    tick();
    run = 1'b0;
    raise(16'h0200);
    prot_unlock_i = 1'b1;
    tick();
    prot_unlock_i = 1'b0;
    run = 1'b1;
    quiet(3);
    serve(4'h9);
    do_ret();
    asleep_i = 1'b1;
    startup_cyc_i = 8'h02;
    raise(16'h0001);
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 60);
    chk("wake_ack", 16'h0001, {15'h0, ack_o});
    repeat (10) @(negedge ref_clk_i);
    chk("wake_load", 16'h0001, {15'h0, pc_load_o});
    tick();
    asleep_i = 1'b0;
    do_ret();
  endtask

  initial begin
    {reset_n_i, global_en_i, round_robin_enable_i, vector_section_select_i} = 4'h0;
    {pri_wr_i, pc_wide_i, prot_unlock_i, locked_exec_i, asleep_i, wake_i} = 6'h00;
    {low_level_enable_i, mid_level_enable_i, high_level_enable_i} = 3'h7;
    {cond_i, clr_flag_i, nmi_src_i, level_i} = 80'h0;
    autoclr_i = 16'hFFFF;
    boot_reset_addr_i = 16'h1000;
    boot_reset_select_i = 1'b0;
    pri_wdata_i = 8'h00;
    startup_cyc_i = 8'h00;
    {ret_req, acks, num_errors, check_count, cycles} = 0;
    run = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1;
    reset_n_i = 1'b1;
    tick(3);
    test_gating();
    test_nesting();
    test_nmi();
    test_round_robin();
    test_misc();
    report_and_stop();
  end
endmodule // multilevel_interrupt_controller_tb_top
